// >>> core/tbsr_regs.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * time base and stop-recovery controller.
 * Assumes the 40 MHz system clock and a 32.768 kHz slow clock.
 */
`ifndef TBSR_REGS_SVH
`define TBSR_REGS_SVH

`define TBSR_OFS_TB 8'h06
`define TBSR_OFS_TICK 8'h07
`define TBSR_OFS_SMR 8'h0b
`define TBSR_OFS_WATCHDOG_MODE_REGISTER 8'h0f

`define TBSR_TB_SEL 1:0
`define TBSR_TB_RUN 2
`define TBSR_TB_CLK 3
`define TBSR_TB_CHIP 4
`define TBSR_SMR_DIV16 0
`define TBSR_SMR_DIV1 1
`define TBSR_SMR_SRC 4:2
`define TBSR_SMR_DLY 5
`define TBSR_SMR_POL 6
`define TBSR_SMR_WARM 7
`define TBSR_WD_ACT_STOP 3
`define TBSR_WD_RCSRC 4

`define TBSR_SMR_DLY_RST 1'h1
`define TBSR_SMR_POL_RST 1'h0
`define TBSR_WATCHDOG_MODE_REGISTER_RST 5'h0e
`define TBSR_WARM_VEC 12'h00c
`define TBSR_COLD_VEC 12'h000

`define TBSR_CLK_HZ 40000000
`define TBSR_SLOW_HZ 32768
`define TBSR_RST_DLY_US 5000
`define TBSR_RST_DLY_CYC (`TBSR_RST_DLY_US * (`TBSR_CLK_HZ / 1000000))
`define TBSR_QS_EDGES (`TBSR_SLOW_HZ / 4)
`define TBSR_POR_QS 6
`define TBSR_SW_EDGES 8'h80
`define TBSR_FAST_RC 27'h12
`define TBSR_WDT_RC 18'h200
`define TBSR_WATCHDOG_MODE_REGISTER_WIN 7'h40

`endif

// >>> core/tbsr_pkg.sv
/*
 * Types of the time base and stop-recovery controller.
 * Assumes tbsr_regs.svh carries all numbers.
 */
package tbsr_pkg;
  typedef enum logic [1:0] {
    TBSR_POR,
    TBSR_RUN,
    TBSR_STOP,
    TBSR_RECOV
  } tbsr_state_t;
endpackage

// >>> core/tbsr_sync.sv
/*
 * Two-flop synchroniser for asynchronous pin levels.
 * Assumes levels stay long enough to be seen on clk.
 */
`timescale 1ns/1ps
module tbsr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] a;
    logic [W-1:0] b;
  } tbsr_sync_t;

  tbsr_sync_t s;
  tbsr_sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.a = d;
    next_s.b = s.a;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.b;
endmodule

// >>> core/tbsr_ctrl.sv
/*
 * Time base, core clock select, stop recovery, reset timing, watchdog.
 * Assumes core-side strobes are on clk; pins are asynchronous.
 */
// Operation
// - Time base expiry in stop: warm restart 000C
// - Running expiry sets tick request; ack/software clear
// - Period field picks quarter second to hour
// - Run bit stops, restarts, reads status
// - Clock source bit picks oscillator or slow
// - Cold source is parameter; warm keeps fields
// - Wait 128 slow edges before oscillator changeover
// - Glitch-free switch; bit changes when complete
// - Oscillator off unless selected; time base runs
// - Recovery source field selects wake input
// - Analog port3 lines never wake
// - Delay bit: 5 ms or 18 RC cycles
// - Polarity bit picks wake level, resets low
// - Warm flag set in stop, cold clears
// - Recovery register write-only except flag
// - Divide-by-one bit bypasses halving
// - Divide-by-16 prescaler for system clock
// - Oscillator cold start holds reset 5 ms
// - Slow cold start times from time base
// - Retriggerable watchdog one-shot resets core
// - Watchdog source: 5 ms or 512 RC
// - Chip-only select bit stored and output
// - Slow cold start holds 1.5 seconds
// - Watchdog mode writable 64 cycles only
`timescale 1ns/1ps
`include "tbsr_regs.svh"
module tbsr_ctrl #(
  parameter logic COLD_SLOW = 1'h0,
  parameter int RST_DLY = `TBSR_RST_DLY_CYC,
  parameter int QS_EDGES = `TBSR_QS_EDGES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic slow_clk_in,
  input wire logic rc_clock_input,
  input wire logic port3_bit1,
  input wire logic port3_bit3,
  input wire logic [7:0] port2,
  input wire logic p31_analog,
  input wire logic p33_analog,
  input wire logic stop_mode,
  input wire logic wdt_instr,
  input wire logic irq_ack,
  output logic tick_interrupt_request,
  output logic core_reset_n,
  output logic [11:0] restart_addr,
  output logic core_clk_sel,
  output logic rc_osc_en,
  output logic sys_clk_en,
  output logic chip_only_select_bit
);
  typedef struct packed {
    tbsr_pkg::tbsr_state_t st;
    logic [1:0] tb_sel;
    logic tb_run;
    logic clk_src;
    logic clk_req;
    logic rc_en;
    logic chip_only;
    logic [26:0] tb_cnt;
    logic [7:0] sw_cnt;
    logic tick;
    logic div16;
    logic div1;
    logic [2:0] src;
    logic dly_long;
    logic pol;
    logic warm;
    logic [4:0] watchdog_mode_register;
    logic wdt_on;
    logic [17:0] wdt_cnt;
    logic [6:0] win_cnt;
    logic [26:0] dly;
    logic slow_q;
    logic rc_q;
    logic [4:0] pre_cnt;
    logic sys_en;
    logic rst_o;
    logic [11:0] vec;
    logic [7:0] rdata;
  } tbsr_ctrl_t;

  tbsr_ctrl_t s;
  tbsr_ctrl_t next_s;
  logic [12:0] pins;
  logic slow_edge;
  logic rc_edge;
  logic [26:0] interval;
  logic tb_exp;
  logic wake_lvl;
  logic wake_ok;
  logic wake_hit;
  logic wdt_tick;
  logic wdt_exp;
  logic wdt_live;
  logic [4:0] pre_last;
  logic wr_tb;
  logic wr_smr;

  // All pin levels cross into clk before any use
  tbsr_sync #(.W(13)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({slow_clk_in, rc_clock_input, port3_bit1, port3_bit3, port2, 1'h0}),
    .q(pins)
  );

  assign slow_edge = pins[12] & ~s.slow_q;
  assign rc_edge = pins[11] & ~s.rc_q;
  assign wr_tb = wr && addr == `TBSR_OFS_TB;
  assign wr_smr = wr && addr == `TBSR_OFS_SMR;

  always_comb begin
    case (s.tb_sel)
      2'h0: interval = 27'(QS_EDGES);
      2'h1: interval = 27'(QS_EDGES * 4);
      2'h2: interval = 27'(QS_EDGES * 240);
      default: interval = 27'(QS_EDGES * 14400);
    endcase
  end

  assign tb_exp = s.tb_run && slow_edge && s.tb_cnt == interval - 27'h1;

  // Analog port3 lines are masked off as wake sources
  always_comb begin
    wake_lvl = 1'h0;
    wake_ok = 1'h1;
    case (s.src)
      3'h2: begin
        wake_lvl = pins[10];
        wake_ok = ~p31_analog;
      end
      3'h4: begin
        wake_lvl = pins[9];
        wake_ok = ~p33_analog;
      end
      3'h5: wake_lvl = pins[8];
      3'h6: wake_lvl = ~|pins[4:1];
      3'h7: wake_lvl = ~|pins[8:1];
      default: wake_ok = 1'h0;
    endcase
  end

  assign wake_hit = (wake_ok && wake_lvl == s.pol) || tb_exp;

  assign wdt_tick = s.watchdog_mode_register[`TBSR_WD_RCSRC] ? rc_edge : 1'h1;
  assign wdt_exp = s.watchdog_mode_register[`TBSR_WD_RCSRC] ? s.wdt_cnt == `TBSR_WDT_RC - 18'h1 :
                   s.wdt_cnt == 18'(RST_DLY - 1);
  assign wdt_live = s.wdt_on &&
                    (s.st == tbsr_pkg::TBSR_RUN ||
                     (s.st == tbsr_pkg::TBSR_STOP && s.watchdog_mode_register[`TBSR_WD_ACT_STOP]));
  // Terminal count of the prescaler: 1, 2, 16 or 32 clk per pulse
  assign pre_last = s.div16 ? (s.div1 ? 5'h0f : 5'h1f) : (s.div1 ? 5'h00 : 5'h01);

  always_comb begin
    next_s = s;
    next_s.slow_q = pins[12];
    next_s.rc_q = pins[11];
    next_s.rdata = 8'h00;
    next_s.sys_en = 1'h0;
    if (s.pre_cnt >= pre_last) begin
      next_s.pre_cnt = 5'h00;
      next_s.sys_en = 1'h1;
    end else begin
      next_s.pre_cnt = s.pre_cnt + 5'h01;
    end
    // Time base keeps counting whatever clocks the core
    if (s.tb_run && slow_edge) begin
      next_s.tb_cnt = tb_exp ? 27'h0 : s.tb_cnt + 27'h1;
    end
    if (s.clk_req && !s.clk_src) begin
      if (slow_edge) begin
        next_s.clk_src = 1'h1;
      end
    end else if (!s.clk_req && s.clk_src) begin
      if (slow_edge) begin
        next_s.sw_cnt = s.sw_cnt + 8'h01;
      end
      if (slow_edge && s.sw_cnt == `TBSR_SW_EDGES - 8'h01) begin
        next_s.clk_src = 1'h0;
        next_s.sw_cnt = 8'h00;
      end
    end else begin
      next_s.sw_cnt = 8'h00;
    end
    next_s.rc_en = ~next_s.clk_src | ~s.clk_req;
    // Set beats clear when both land together
    if (irq_ack || (wr && addr == `TBSR_OFS_TICK && !wdata[0])) begin
      next_s.tick = 1'h0;
    end
    if (tb_exp && s.st != tbsr_pkg::TBSR_STOP) begin
      next_s.tick = 1'h1;
    end
    if (wr_tb) begin
      next_s.tb_sel = wdata[`TBSR_TB_SEL];
      next_s.tb_run = wdata[`TBSR_TB_RUN];
      next_s.clk_req = wdata[`TBSR_TB_CLK];
      next_s.chip_only = wdata[`TBSR_TB_CHIP];
      if (wdata[`TBSR_TB_RUN]) begin
        next_s.tb_cnt = 27'h0;
      end
    end
    if (wr_smr) begin
      next_s.div16 = wdata[`TBSR_SMR_DIV16];
      next_s.div1 = wdata[`TBSR_SMR_DIV1];
      next_s.src = wdata[`TBSR_SMR_SRC];
      next_s.dly_long = wdata[`TBSR_SMR_DLY];
      next_s.pol = wdata[`TBSR_SMR_POL];
    end
    if (wr && addr == `TBSR_OFS_WATCHDOG_MODE_REGISTER && s.win_cnt < `TBSR_WATCHDOG_MODE_REGISTER_WIN) begin
      next_s.watchdog_mode_register = wdata[4:0];
    end
    if (s.st == tbsr_pkg::TBSR_RUN && s.sys_en && s.win_cnt < `TBSR_WATCHDOG_MODE_REGISTER_WIN) begin
      next_s.win_cnt = s.win_cnt + 7'h01;
    end
    if (rd) begin
      case (addr)
        `TBSR_OFS_TB: next_s.rdata = {3'h0, s.chip_only, s.clk_src, s.tb_run, s.tb_sel};
        `TBSR_OFS_TICK: next_s.rdata = {7'h00, s.tick};
        `TBSR_OFS_SMR: next_s.rdata = {s.warm, 7'h00};
        default: next_s.rdata = 8'h00;
      endcase
    end
    if (wdt_live && wdt_tick) begin
      next_s.wdt_cnt = s.wdt_cnt + 18'h1;
    end
    if (s.st == tbsr_pkg::TBSR_RUN && wdt_instr) begin
      next_s.wdt_on = 1'h1;
      next_s.wdt_cnt = 18'h0;
    end
    case (s.st)
      tbsr_pkg::TBSR_POR: begin
        if (COLD_SLOW) begin
          if (slow_edge) begin
            next_s.dly = s.dly + 27'h1;
          end
          if (s.dly == 27'(QS_EDGES * `TBSR_POR_QS)) begin
            next_s.rst_o = 1'h1;
            next_s.st = tbsr_pkg::TBSR_RUN;
          end
        end else begin
          next_s.dly = s.dly + 27'h1;
          if (s.dly == 27'(RST_DLY - 1)) begin
            next_s.rst_o = 1'h1;
            next_s.st = tbsr_pkg::TBSR_RUN;
          end
        end
      end
      tbsr_pkg::TBSR_RUN: begin
        if (wdt_live && wdt_tick && wdt_exp) begin
          next_s.warm = 1'h0;
          next_s.vec = `TBSR_COLD_VEC;
          next_s.st = tbsr_pkg::TBSR_RECOV;
        end else if (stop_mode) begin
          next_s.warm = 1'h1;
          next_s.st = tbsr_pkg::TBSR_STOP;
        end
      end
      tbsr_pkg::TBSR_STOP: begin
        // Register fields are left alone on warm start
        if (wake_hit || (wdt_live && wdt_tick && wdt_exp)) begin
          next_s.vec = `TBSR_WARM_VEC;
          next_s.st = tbsr_pkg::TBSR_RECOV;
        end
      end
      tbsr_pkg::TBSR_RECOV: begin
        if (s.dly_long || rc_edge) begin
          next_s.dly = s.dly + 27'h1;
        end
        if (s.dly_long ? s.dly == 27'(RST_DLY - 1) : s.dly == `TBSR_FAST_RC) begin
          next_s.rst_o = 1'h1;
          next_s.st = tbsr_pkg::TBSR_RUN;
        end
      end
      default: next_s.st = tbsr_pkg::TBSR_POR;
    endcase
    if (next_s.st != s.st) begin
      next_s.dly = 27'h0;
      if (next_s.st == tbsr_pkg::TBSR_RECOV) begin
        next_s.rst_o = 1'h0;
        next_s.wdt_on = 1'h0;
        next_s.wdt_cnt = 18'h0;
      end
      if (next_s.st == tbsr_pkg::TBSR_RUN) begin
        next_s.win_cnt = 7'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= tbsr_pkg::TBSR_POR;
      s.clk_src <= COLD_SLOW;
      s.clk_req <= COLD_SLOW;
      s.rc_en <= ~COLD_SLOW;
      s.dly_long <= `TBSR_SMR_DLY_RST;
      s.pol <= `TBSR_SMR_POL_RST;
      s.watchdog_mode_register <= `TBSR_WATCHDOG_MODE_REGISTER_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign tick_interrupt_request = s.tick;
  assign core_reset_n = s.rst_o;
  assign restart_addr = s.vec;
  assign core_clk_sel = s.clk_src;
  assign rc_osc_en = s.rc_en;
  assign sys_clk_en = s.sys_en;
  assign chip_only_select_bit = s.chip_only;

  sequence s_stop_wake;
    s.st == tbsr_pkg::TBSR_STOP && wake_hit;
  endsequence
  sequence s_warm_reset;
    !core_reset_n && restart_addr == `TBSR_WARM_VEC;
  endsequence

  property p_warm_vec;
    @(posedge clk) disable iff (!rst_n) s_stop_wake |=> s_warm_reset;
  endproperty
  a_warm_vec: assert property (p_warm_vec) else $error("no warm restart");

  property p_tick;
    @(posedge clk) disable iff (!rst_n)
      tb_exp && s.st != tbsr_pkg::TBSR_STOP |=> tick_interrupt_request;
  endproperty
  a_tick: assert property (p_tick) else $error("tick not set");

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      wr_tb && wdata[`TBSR_TB_RUN] |=> s.tb_cnt == 27'h0 && s.tb_run;
  endproperty
  a_restart: assert property (p_restart) else $error("time base not restarted");

  property p_to_slow;
    @(posedge clk) disable iff (!rst_n)
      s.clk_req && !core_clk_sel && slow_edge |=> core_clk_sel;
  endproperty
  a_to_slow: assert property (p_to_slow) else $error("slow switch missed");

  property p_to_rc;
    @(posedge clk) disable iff (!rst_n)
      $fell(core_clk_sel) |-> $past(s.sw_cnt) == `TBSR_SW_EDGES - 8'h01;
  endproperty
  a_to_rc: assert property (p_to_rc) else $error("switched before 128 edges");

  property p_sel_edge;
    @(posedge clk) disable iff (!rst_n) $changed(core_clk_sel) |-> $past(slow_edge);
  endproperty
  a_sel_edge: assert property (p_sel_edge) else $error("switch off slow edge");

  property p_rc_on;
    @(posedge clk) disable iff (!rst_n) !core_clk_sel |-> rc_osc_en;
  endproperty
  a_rc_on: assert property (p_rc_on) else $error("oscillator off while used");

  property p_warm_flag;
    @(posedge clk) disable iff (!rst_n)
      s.st == tbsr_pkg::TBSR_RUN && stop_mode && !(wdt_live && wdt_tick && wdt_exp)
      |=> s.warm ##1 s.warm;
  endproperty
  a_warm_flag: assert property (p_warm_flag) else $error("warm flag lost");

  property p_wd_lock;
    @(posedge clk) disable iff (!rst_n)
      wr && addr == `TBSR_OFS_WATCHDOG_MODE_REGISTER && s.win_cnt >= `TBSR_WATCHDOG_MODE_REGISTER_WIN |=> $stable(s.watchdog_mode_register);
  endproperty
  a_wd_lock: assert property (p_wd_lock) else $error("watchdog mode not locked");
endmodule

// >>> tb/tbsr_far.sv
/*
 * Far-side model: slow crystal and RC clock pins of the controller.
 * Assumes the bench plays the core and the wake pins itself.
 */
`timescale 1ns/1ps
module tbsr_far #(
  parameter int SLOW_HALF_NS = 250,
  parameter int RC_HALF_NS = 40
) (
  output logic slow_clk_in,
  output logic rc_clock_input
);
  // Crystal sped up so the long periods fit the run
  initial begin
    slow_clk_in = 1'b0;
    forever #(SLOW_HALF_NS) slow_clk_in = ~slow_clk_in;
  end
  // Offset start keeps the RC clock unrelated to clk
  initial begin
    rc_clock_input = 1'b0;
    #7;
    forever #(RC_HALF_NS) rc_clock_input = ~rc_clock_input;
  end
endmodule

// >>> tb/tb_tbsr_ctrl.sv
/*
 * Self-checking bench of the time base and stop-recovery controller.
 * Assumes tbsr_far gives a slow clock of 20 clk cycles per period.
 */
`timescale 1ns/1ps
module tb_tbsr_ctrl;
  localparam int RST_DLY = 200;
  localparam int QS = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic port3_bit1 = 1'b0;
  logic p31_analog = 1'b0;
  logic port3_bit3 = 1'b0;
  logic p33_analog = 1'b0;
  logic [7:0] port2 = 8'hff;
  logic stop_mode = 1'b0;
  logic wdt_instr = 1'b0;
  logic irq_ack = 1'b0;
  logic [7:0] rdata;
  logic [11:0] restart_addr;
  logic slow_clk_in, rc_clock_input, tick_interrupt_request, core_reset_n;
  logic core_clk_sel, rc_osc_en, sys_clk_en, chip_only_select_bit;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  tbsr_far i_far (.slow_clk_in, .rc_clock_input);
  tbsr_ctrl #(.COLD_SLOW(1'h0), .RST_DLY(RST_DLY), .QS_EDGES(QS)) i_dut (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .slow_clk_in, .rc_clock_input,
    .port3_bit1, .port3_bit3, .port2, .p31_analog, .p33_analog,
    .stop_mode, .wdt_instr, .irq_ack, .tick_interrupt_request, .core_reset_n,
    .restart_addr, .core_clk_sel, .rc_osc_en, .sys_clk_en, .chip_only_select_bit
  );

  always #12.5 clk = ~clk;

  task automatic results();
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      results();
    end
  end

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  function automatic logic [15:0] near(input int n, input int e);
    return (n >= e - 1 && n <= e + 1) ? 16'(e) : 16'(n);
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_sig(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Counts raw slow edges until s reaches v
  task automatic count_slow(ref logic s, input logic v, input int lim, output int n);
    logic prev;
    int c;
    prev = slow_clk_in;
    n = 0;
    c = 0;
    while (s !== v && c < lim) begin
      @(posedge clk);
      #1;
      c++;
      if (slow_clk_in && !prev)
        n++;
      prev = slow_clk_in;
    end
  endtask

  task automatic t_reset();
    logic [7:0] d;
    int n;
    chk(1'b1, rc_osc_en);
    chk(1'b0, core_clk_sel);
    wait_sig(core_reset_n, 1'b1, RST_DLY + 20, n);
    chk(1, n >= RST_DLY - 3 && core_reset_n === 1'b1);
    rd_reg(8'h0b, d);
    chk(8'h00, d);
    rd_reg(8'h33, d);
    chk(8'h00, d);
  endtask

  task automatic t_div();
    logic [7:0] stop_recovery_reg [4] = '{8'h22, 8'h20, 8'h23, 8'h21};
    int exp [4] = '{64, 32, 4, 2};
    logic [7:0] d;
    int n;
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h0b, stop_recovery_reg[i]);
      repeat (40) @(posedge clk);
      #1;
      n = 0;
      repeat (64) begin
        @(posedge clk);
        #1;
        n += int'(sys_clk_en === 1'b1);
      end
      chk(exp[i], n);
    end
    rd_reg(8'h0b, d);
    chk(8'h00, d);
  endtask

  task automatic t_tick();
    int per [3] = '{1, 4, 240};
    logic [7:0] d;
    int n;
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h06, 8'h04 | 8'(i));
      count_slow(tick_interrupt_request, 1'b1, per[i] * QS * 20 + 200, n);
      chk(per[i] * QS, near(n, per[i] * QS));
      rd_reg(8'h07, d);
      chk(8'h01, {7'h00, d[0]});
      rd_reg(8'h06, d);
      chk(1'b1, d[2]);
      if (i == 0) begin
        @(posedge clk);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
      end else begin
        wr_reg(8'h07, 8'h00);
      end
      repeat (2) @(posedge clk);
      #1;
      chk(1'b0, tick_interrupt_request);
    end
    wr_reg(8'h06, 8'h00);
    count_slow(tick_interrupt_request, 1'b1, QS * 60, n);
    chk(1'b0, tick_interrupt_request);
    rd_reg(8'h06, d);
    chk(1'b0, d[2]);
  endtask

  task automatic t_clk();
    logic [7:0] d;
    int n;
    wr_reg(8'h06, 8'h08);
    wait_sig(core_clk_sel, 1'b1, 100, n);
    chk(1'b1, core_clk_sel);
    chk(1'b0, rc_osc_en);
    rd_reg(8'h06, d);
    chk(1'b1, d[3]);
    wr_reg(8'h06, 8'h00);
    repeat (100) @(posedge slow_clk_in);
    #1;
    chk(1'b1, core_clk_sel);
    rd_reg(8'h06, d);
    chk(1'b1, d[3]);
    count_slow(core_clk_sel, 1'b0, 1200, n);
    chk(128, near(100 + n, 128));
    rd_reg(8'h06, d);
    chk(1'b0, d[3]);
    chk(1'b1, rc_osc_en);
  endtask

  task automatic t_stop();
    logic [7:0] d;
    int n;
    wr_reg(8'h06, 8'h10);
    @(posedge clk);
    #1;
    chk(1'b1, chip_only_select_bit);
    wr_reg(8'h0b, 8'h48);
    @(posedge clk);
    p31_analog <= 1'b1;
    port3_bit1 <= 1'b1;
    stop_mode <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk(1'b1, core_reset_n);
    @(posedge clk);
    p31_analog <= 1'b0;
    wait_sig(core_reset_n, 1'b0, 10, n);
    chk(1'b0, core_reset_n);
    chk(12'h00c, restart_addr);
    @(posedge clk);
    stop_mode <= 1'b0;
    port3_bit1 <= 1'b0;
    wait_sig(core_reset_n, 1'b1, 150, n);
    chk(1, n >= 50 && n <= 75);
    rd_reg(8'h0b, d);
    chk(8'h80, d);
    rd_reg(8'h06, d);
    chk(8'h10, d);
    wr_reg(8'h0b, 8'h00);
    wr_reg(8'h06, 8'h04);
    @(posedge clk);
    stop_mode <= 1'b1;
    wait_sig(core_reset_n, 1'b0, QS * 40 + 100, n);
    chk(1'b0, core_reset_n);
    chk(12'h00c, restart_addr);
    chk(1'b0, tick_interrupt_request);
    @(posedge clk);
    stop_mode <= 1'b0;
    wait_sig(core_reset_n, 1'b1, 150, n);
    wr_reg(8'h06, 8'h00);
    wr_reg(8'h07, 8'h00);
  endtask

  // Port 2 low-nibble NOR and port3_bit3 wake sources, high level
  task automatic t_wake();
    int n;
    wr_reg(8'h0b, 8'h58);
    @(posedge clk);
    port2 <= 8'h0f;
    stop_mode <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk(1'b1, core_reset_n);
    @(posedge clk);
    port2 <= 8'hf0;
    wait_sig(core_reset_n, 1'b0, 10, n);
    chk(1'b0, core_reset_n);
    chk(12'h00c, restart_addr);
    @(posedge clk);
    stop_mode <= 1'b0;
    port2 <= 8'hff;
    wait_sig(core_reset_n, 1'b1, 150, n);
    chk(1'b1, core_reset_n);
    wr_reg(8'h0b, 8'h50);
    @(posedge clk);
    p33_analog <= 1'b1;
    port3_bit3 <= 1'b1;
    stop_mode <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk(1'b1, core_reset_n);
    @(posedge clk);
    p33_analog <= 1'b0;
    wait_sig(core_reset_n, 1'b0, 10, n);
    chk(1'b0, core_reset_n);
    @(posedge clk);
    stop_mode <= 1'b0;
    port3_bit3 <= 1'b0;
    wait_sig(core_reset_n, 1'b1, 150, n);
    wr_reg(8'h0b, 8'h00);
  endtask

  task automatic t_wdt();
    logic [7:0] d;
    int n;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      wdt_instr <= 1'b1;
      @(posedge clk);
      wdt_instr <= 1'b0;
      repeat (150) @(posedge clk);
    end
    repeat (30) @(posedge clk);
    #1;
    chk(1'b1, core_reset_n);
    wait_sig(core_reset_n, 1'b0, 60, n);
    chk(1'b0, core_reset_n);
    chk(12'h000, restart_addr);
    wait_sig(core_reset_n, 1'b1, 300, n);
    rd_reg(8'h0b, d);
    chk(8'h00, d);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_div();
    t_tick();
    t_clk();
    t_stop();
    t_wake();
    t_wdt();
    results();
  end
endmodule
